/* File: mpr_top.sv */
// Mode pin decoding, output routing and lock supervision.
// Assumes clock inputs and pins are sampled at 40 MHz; the PLL core reports pll_lock_in.
//
// Overview of operation
// - Auxiliary pin carries one of four sources picked by aux_source_select.
// - Encoding 00 reference, 01 sync input, 10 synthesized clock, 11 lock.
// - Lock indicator driver type and polarity come from lock_pin_style.
// - Style 0 push-pull high when unlocked; style 1 open drain low when unlocked.
// - Auxiliary synthesized clock is not assumed phase-aligned with the main output.
// - Functions 001 and 010 let the function pin float the auxiliary driver.
// - Functions 000-010 make the function pin an active-high output disable.
// - 000 disables synthesized output, 001 auxiliary, 010 both.
// - Mode pins pick one of 4 modal sets; global settings are shared.
// - Only function 011 with pin high enables the ratio modifier.
// - Function 100 pin high hands source choice to fraction_source when automatic.
// - Function 110 pin selects static or dynamic ratio unless automatic switching.
// - Function 111 pin high forces auxiliary source to synthesized clock.
// - Enables, 00/10 switches, mode switches and unlock blanking never make runts.
// - Partial periods allowed for source 11 enables and switches touching 01/11.
// - Any mode pin change causes a temporary loss of lock.
// - Function pin change under 011, 100, 101, 110 causes temporary unlock.
// - Discontinuity of the reference drops lock; sync clock loss drops it only while frac_dynamic_q is set.
// - Sync step change or drift beyond 30 percent drops lock.
// - After lock time elapses the configured clock is output.
// - Ratio shift 00 divides by 2 up to 11 dividing by 16.
`timescale 1ns/1ps

module mpr_top
  import mpr_pkg::*;
#(
  parameter int unsigned SYNC_TIMEOUT_CYC = SYNC_TIMEOUT
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        mode_select_low_pin,
  input  wire logic        mode_select_high_pin,
  input  wire logic        function_pin,
  input  wire logic        timing_reference_clock,
  input  wire logic        ref_clock_valid,
  input  wire logic        sync_clock_in,
  input  wire logic        synth_clock_in,
  input  wire logic        pll_lock_in,
  output logic             synth_out_q,
  output logic             synth_oe_q,
  output logic             aux_out_q,
  output logic             aux_oe_q,
  output logic             frac_dynamic_q,
  output logic [31:0]      effective_ratio_q,
  output logic             locked_q
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Period outside +-30 percent of a reference period
  function automatic logic out_of_band(input logic [23:0] p, input logic [23:0] ref_p);
    logic [31:0] p100;
    logic [31:0] lo;
    logic [31:0] hi;
    p100 = 32'(p) * 32'd100;
    lo   = 32'(ref_p) * 32'(100 - DRIFT_PCT);
    hi   = 32'(ref_p) * 32'(100 + DRIFT_PCT);
    return (p100 < lo) || (p100 > hi);
  endfunction

  // ==========================================================================
  // Register file
  logic [4:0]  ctrl_q;
  logic [6:0]  modal_q [4];
  logic [31:0] ratio_q [4];
  logic [31:0] rd_d;
  logic        wait_q;
  logic        take;
  logic [31:0] status;

  assign avs_waitrequest = wait_q;
  assign take = (avs_read || avs_write) && !wait_q;

  // One wait cycle per access; the accepting edge is the one with waitrequest low
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address == OFS_CTRL) begin
      rd_d = {27'h0, ctrl_q};
    end else if (avs_address == OFS_STATUS) begin
      rd_d = status;
    end else if (avs_address == OFS_EFF) begin
      rd_d = effective_ratio_q;
    end else if (avs_address[7:4] == OFS_MODAL0[7:4] && avs_address[1:0] == 2'b00) begin
      rd_d = {25'h0, modal_q[avs_address[3:2]]};
    end else if (avs_address[7:4] == OFS_RATIO0[7:4] && avs_address[1:0] == 2'b00) begin
      rd_d = ratio_q[avs_address[3:2]];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && wait_q) begin
      avs_readdata <= rd_d;
    end
  end

  logic [31:0] wr_m;
  assign wr_m = be_merge({27'h0, ctrl_q}, avs_writedata, avs_byteenable);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
      for (int i = 0; i < 4; i++) begin
        modal_q[i] <= MODAL_RST;
        ratio_q[i] <= RATIO_RST;
      end
    end else if (take && avs_write && avs_address[1:0] == 2'b00) begin
      if (avs_address == OFS_CTRL) begin
        ctrl_q <= wr_m[4:0];
      end else if (avs_address[7:4] == OFS_MODAL0[7:4]) begin
        modal_q[avs_address[3:2]] <=
          7'(be_merge({25'h0, modal_q[avs_address[3:2]]}, avs_writedata, avs_byteenable));
      end else if (avs_address[7:4] == OFS_RATIO0[7:4]) begin
        ratio_q[avs_address[3:2]] <=
          be_merge(ratio_q[avs_address[3:2]], avs_writedata, avs_byteenable);
      end
    end
  end

  // ==========================================================================
  // Pin synchronizers
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= {function_pin, mode_select_high_pin, mode_select_low_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // ==========================================================================
  // Mode decode
  mpr_tpf_t    tpf;
  logic [1:0]  mode;
  logic        fpin;
  logic [6:0]  set;
  logic        style;
  logic        unl_en;
  logic        auto_cfg;
  logic        auto_on;
  logic        frac_d;
  logic        rmod_en;
  logic [1:0]  ratio_idx;
  logic [31:0] sel_ratio;
  logic        sync_present_q;

  assign tpf    = mpr_tpf_t'(ctrl_q[CTRL_TPF_LSB +: 3]);
  assign style  = ctrl_q[CTRL_STYLE_BIT];
  assign unl_en = ctrl_q[CTRL_UNL_BIT];
  assign mode   = pin_s2_q[1:0];
  assign fpin   = pin_s2_q[2];
  assign set    = modal_q[mode];
  assign auto_cfg = set[MOD_LOCK_LSB +: 2] != mode;
  assign auto_on  = auto_cfg && !(tpf == TPF_AUTO_OFF && fpin);
  assign rmod_en  = (tpf == TPF_RMOD_EN) && fpin;

  always_comb begin
    if (auto_on) begin
      frac_d = sync_present_q;
    end else if (tpf == TPF_FRAC_OVR) begin
      frac_d = fpin;
    end else begin
      frac_d = set[MOD_FRAC_BIT];
    end
  end

  assign ratio_idx = (auto_on && sync_present_q) ? set[MOD_LOCK_LSB +: 2] : mode;
  assign sel_ratio = ratio_q[ratio_idx];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      frac_dynamic_q    <= 1'b0;
      effective_ratio_q <= RATIO_RST;
    end else begin
      frac_dynamic_q <= frac_d;
      if (rmod_en) begin
        effective_ratio_q <= ratio_q[ratio_idx] >> (3'(set[MOD_SHIFT_LSB +: 2]) + 3'd1);
      end else begin
        effective_ratio_q <= ratio_q[ratio_idx];
      end
    end
  end

  // ==========================================================================
  // Sync clock supervision
  logic        sync_prev_q;
  logic [23:0] per_cnt_q;
  logic [23:0] start_per_q;
  logic [23:0] last_per_q;
  logic        have_start_q;
  logic        sync_edge;
  logic        sync_bad;
  logic        sync_lost;

  assign sync_edge = sync_clock_in && !sync_prev_q;
  assign sync_lost = per_cnt_q == 24'(SYNC_TIMEOUT_CYC);
  assign sync_bad  = sync_edge && have_start_q &&
                     (out_of_band(per_cnt_q, start_per_q) ||
                      out_of_band(per_cnt_q, last_per_q));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync_prev_q    <= 1'b0;
      per_cnt_q      <= 24'h00_0000;
      start_per_q    <= 24'h00_0000;
      last_per_q     <= 24'h00_0000;
      have_start_q   <= 1'b0;
      sync_present_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_clock_in;
      if (sync_edge) begin
        per_cnt_q      <= 24'h00_0001;
        last_per_q     <= per_cnt_q;
        sync_present_q <= sync_present_q || per_cnt_q != 24'h00_0000;
        if (!have_start_q && sync_present_q) begin
          start_per_q  <= per_cnt_q;
          have_start_q <= 1'b1;
        end else if (sync_bad) begin
          have_start_q <= 1'b0;
        end
      end else if (sync_lost) begin
        sync_present_q <= 1'b0;
        have_start_q   <= 1'b0;
        per_cnt_q      <= 24'h00_0000;
      end else if (per_cnt_q != 24'h00_0000) begin
        per_cnt_q <= per_cnt_q + 24'h00_0001;
      end
    end
  end

  // ==========================================================================
  // Lock supervision
  mpr_lock_t   lk_q;
  logic [15:0] hold_q;
  logic        mode_chg;
  logic        func_chg;
  logic        unlock_ev;

  assign mode_chg = pin_s2_q[1:0] != pin_s3_q[1:0];
  assign func_chg = (pin_s2_q[2] != pin_s3_q[2]) &&
                    (tpf inside {TPF_RMOD_EN, TPF_AUTO_OFF, TPF_RSVD, TPF_FRAC_OVR});
  assign unlock_ev = mode_chg || func_chg || !ref_clock_valid || sync_bad ||
                     (sync_lost && frac_dynamic_q);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      lk_q   <= LK_HOLD;
      hold_q <= 16'(LOCK_CYC);
    end else if (unlock_ev) begin
      lk_q   <= LK_HOLD;
      hold_q <= 16'(LOCK_CYC);
    end else begin
      unique case (lk_q)
        LK_HOLD: begin
          if (hold_q == 16'h0001) begin
            lk_q <= LK_WAIT;
          end
          hold_q <= hold_q - 16'h0001;
        end
        LK_WAIT: begin
          if (pll_lock_in) begin
            lk_q <= LK_LOCK;
          end
        end
        LK_LOCK: begin
          if (!pll_lock_in) begin
            lk_q <= LK_WAIT;
          end
        end
        default: begin
          lk_q <= LK_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= (lk_q == LK_LOCK) && !unlock_ev;
    end
  end

  // ==========================================================================
  // Synthesized clock output
  logic clk_dis;
  logic clk_run_q;

  assign clk_dis = fpin && (tpf == TPF_DIS_CLK || tpf == TPF_DIS_BOTH);

  // Gates change only while the clock is low, so no runt can escape
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clk_run_q   <= 1'b0;
      synth_oe_q  <= 1'b0;
      synth_out_q <= 1'b0;
    end else begin
      if (!synth_clock_in) begin
        clk_run_q  <= locked_q || unl_en;
        synth_oe_q <= !clk_dis;
      end
      synth_out_q <= clk_run_q && synth_clock_in;
    end
  end

  // ==========================================================================
  // Auxiliary output
  function automatic logic src_val(input logic [1:0] s, input logic r, input logic y,
                                   input logic c, input logic l);
    unique case (s)
      AUX_REF:   return r;
      AUX_SYNC:  return y;
      AUX_SYNTH: return c;
      default:   return !l;
    endcase
  endfunction

  logic [1:0] aux_tgt;
  logic [1:0] aux_act_q;
  logic       aux_en_q;
  logic       aux_dis;
  logic       cur_v;
  logic       tgt_v;
  logic       glitchless;

  assign aux_tgt = (tpf == TPF_AUX_SYN && fpin) ? AUX_SYNTH : set[MOD_AUX_LSB +: 2];
  assign aux_dis = fpin && (tpf == TPF_DIS_AUX || tpf == TPF_DIS_BOTH);
  assign cur_v = src_val(aux_act_q, timing_reference_clock, sync_clock_in,
                         synth_clock_in, locked_q);
  assign tgt_v = src_val(aux_tgt, timing_reference_clock, sync_clock_in,
                         synth_clock_in, locked_q);
  assign glitchless = !aux_act_q[0] && !aux_tgt[0];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      aux_act_q <= AUX_REF;
      aux_en_q  <= 1'b0;
    end else begin
      if (aux_tgt != aux_act_q && (!glitchless || (!cur_v && !tgt_v))) begin
        aux_act_q <= aux_tgt;
      end
      if (!cur_v || aux_act_q == AUX_LOCK) begin
        aux_en_q <= !aux_dis;
      end
    end
  end

  // Own register stage: phase may differ from the main synthesized pin
  always_ff @(posedge clock) begin
    if (!rstn) begin
      aux_out_q <= 1'b0;
      aux_oe_q  <= 1'b0;
    end else if (!aux_en_q) begin
      aux_out_q <= 1'b0;
      aux_oe_q  <= 1'b0;
    end else if (aux_act_q == AUX_LOCK && style) begin
      aux_out_q <= 1'b0;
      aux_oe_q  <= !locked_q;
    end else begin
      aux_out_q <= cur_v;
      aux_oe_q  <= 1'b1;
    end
  end

  assign status = {20'h0, lk_q, sync_present_q, aux_act_q, rmod_en, auto_on,
                   frac_dynamic_q, locked_q, fpin, mode};

  // ==========================================================================
  // Checks
  a_aux_push_pull: assert property (@(posedge clock) disable iff (!rstn)
    (aux_en_q && aux_act_q == AUX_LOCK && !style) |=> (aux_oe_q && aux_out_q == !$past(locked_q)))
    else $error("push-pull lock level wrong");
  a_aux_open_drain: assert property (@(posedge clock) disable iff (!rstn)
    (aux_en_q && aux_act_q == AUX_LOCK && style) |=> (!aux_out_q && aux_oe_q == !$past(locked_q)))
    else $error("open-drain lock level wrong");
  a_aux_hiz_off: assert property (@(posedge clock) disable iff (!rstn)
    (aux_dis && aux_act_q == AUX_LOCK) ##1 1'b1 |=> !aux_oe_q)
    else $error("aux not floated when disabled");
  a_mode_change_unlock: assert property (@(posedge clock) disable iff (!rstn)
    mode_chg |=> (lk_q == LK_HOLD && !locked_q) ##1 !locked_q)
    else $error("mode change kept lock");
  a_func_change_unlock: assert property (@(posedge clock) disable iff (!rstn)
    func_chg |=> !locked_q)
    else $error("function pin change kept lock");
  a_rmod_gate: assert property (@(posedge clock) disable iff (!rstn)
    !rmod_en |=> effective_ratio_q == $past(sel_ratio))
    else $error("ratio modified without enable");
  a_frac_override: assert property (@(posedge clock) disable iff (!rstn)
    (!auto_on && tpf == TPF_FRAC_OVR) |=> frac_dynamic_q == $past(fpin))
    else $error("override not applied");
  a_clk_no_runt: assert property (@(posedge clock) disable iff (!rstn)
    ($rose(synth_oe_q) || $changed(clk_run_q)) |-> !$past(synth_clock_in))
    else $error("output gate moved while clock high");
  a_bus_one_wait: assert property (@(posedge clock) disable iff (!rstn)
    ((avs_read || avs_write) && wait_q) |=> !wait_q ##1 wait_q)
    else $error("bus answer timing wrong");

  c_lock_reached: cover property (@(posedge clock) disable iff (!rstn) $rose(locked_q));
  c_aux_switch: cover property (@(posedge clock) disable iff (!rstn)
    $changed(aux_act_q) && aux_act_q == AUX_SYNTH);
  c_sync_drift: cover property (@(posedge clock) disable iff (!rstn) sync_bad);

endmodule

/* File: mpr_pkg.sv */
// Constants for the mode pin and output routing block.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.
package mpr_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned LOCK_TIME_US    = 1;
  localparam int unsigned LOCK_CYC        = (LOCK_TIME_US * CLK_HZ) / 1_000_000;
  localparam int unsigned SYNC_MIN_HZ     = 50;
  localparam int unsigned SYNC_TIMEOUT    = CLK_HZ / SYNC_MIN_HZ;
  localparam int unsigned DRIFT_PCT       = 30;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_EFF    = 8'h08;
  localparam logic [7:0] OFS_MODAL0 = 8'h10;
  localparam logic [7:0] OFS_RATIO0 = 8'h20;

  // ==========================================================================
  // Control fields
  localparam int CTRL_TPF_LSB   = 0;
  localparam int CTRL_STYLE_BIT = 3;
  localparam int CTRL_UNL_BIT   = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // Modal set fields
  localparam int MOD_SHIFT_LSB = 0;
  localparam int MOD_AUX_LSB   = 2;
  localparam int MOD_LOCK_LSB  = 4;
  localparam int MOD_FRAC_BIT  = 6;
  localparam logic [6:0]  MODAL_RST = 7'h00;
  localparam logic [31:0] RATIO_RST = 32'h0010_0000;

  // ==========================================================================
  // Encodings
  localparam logic [1:0] AUX_REF   = 2'b00;
  localparam logic [1:0] AUX_SYNC  = 2'b01;
  localparam logic [1:0] AUX_SYNTH = 2'b10;
  localparam logic [1:0] AUX_LOCK  = 2'b11;

  typedef enum logic [2:0] {
    TPF_DIS_CLK  = 3'b000,
    TPF_DIS_AUX  = 3'b001,
    TPF_DIS_BOTH = 3'b010,
    TPF_RMOD_EN  = 3'b011,
    TPF_AUTO_OFF = 3'b100,
    TPF_RSVD     = 3'b101,
    TPF_FRAC_OVR = 3'b110,
    TPF_AUX_SYN  = 3'b111
  } mpr_tpf_t;

  typedef enum logic [1:0] {
    LK_HOLD = 2'b00,
    LK_WAIT = 2'b01,
    LK_LOCK = 2'b11
  } mpr_lock_t;

endpackage

/* File: mpr_pin_ctl.sv */
// Board controller model that drives the three mode pins of the routing block.
// Assumes the bench calls its tasks from one sequence, clocked by the system clock.
`timescale 1ns/1ps

module mpr_pin_ctl (
  input  wire logic clock,
  input  wire logic rstn,
  output logic      mode_select_low_pin,
  output logic      mode_select_high_pin,
  output logic      function_pin
);

  // ==========================================================================
  // Power-up levels
  // Pins stay static from time zero until initialisation starts
  initial begin
    mode_select_low_pin  = 1'b0;
    mode_select_high_pin = 1'b0;
    function_pin         = 1'b0;
  end

  // ==========================================================================
  // Pin changes, always just after a rising edge
  task automatic set_pins(input logic [1:0] mode, input logic fn);
    @(posedge clock);
    mode_select_low_pin  <= mode[0];
    mode_select_high_pin <= mode[1];
    function_pin         <= fn;
  endtask

  // Field-programmed parts need toggles; spaced so each one is synchronised
  task automatic init_toggle();
    while (rstn !== 1'b1)
      @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      mode_select_low_pin <= ~mode_select_low_pin;
      repeat (4) @(posedge clock);
    end
  endtask

endmodule

/* File: mpr_top_test.sv */
// Self-checking bench for the mode pin and output routing block.
// Assumes the pin model in its own file and the package constants of the design.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end

module mpr_top_test;
  import mpr_pkg::*;

  // ==========================================================================
  // Signals
  logic        clock           = 1'b0;
  logic        rstn            = 1'b0;
  logic [7:0]  avs_address     = 8'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mode_lo, mode_hi, fn_pin;
  logic        ref_clk         = 1'b0;
  logic        ref_valid       = 1'b1;
  logic        synth_clk       = 1'b0;
  logic        pll_lock        = 1'b1;
  logic        sync_clk        = 1'b0;
  int          sync_half       = 0;
  int          sync_cnt        = 0;
  logic        synth_out_q, synth_oe_q, aux_out_q, aux_oe_q, frac_dynamic_q, locked_q;
  logic [31:0] effective_ratio_q;
  logic        probe           = 1'b0;
  logic [63:0] exp_q[$];
  logic [31:0] r;
  int          checks          = 0;
  int          fails           = 0;

  // ==========================================================================
  // Clocks; the reference stops while it is marked discontinuous
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    synth_clk <= ~synth_clk;
    if (ref_valid)
      ref_clk <= ~ref_clk;
    // Sync clock toggles every sync_half edges, stands still at zero
    if (sync_half > 0) begin
      sync_cnt <= (sync_cnt + 1 < sync_half) ? sync_cnt + 1 : 0;
      if (sync_cnt + 1 >= sync_half)
        sync_clk <= ~sync_clk;
    end
  end

  mpr_top #(.SYNC_TIMEOUT_CYC(200)) i_dut (
    .clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .mode_select_low_pin(mode_lo), .mode_select_high_pin(mode_hi), .function_pin(fn_pin),
    .timing_reference_clock(ref_clk), .ref_clock_valid(ref_valid), .sync_clock_in(sync_clk),
    .synth_clock_in(synth_clk), .pll_lock_in(pll_lock), .synth_out_q(synth_out_q),
    .synth_oe_q(synth_oe_q), .aux_out_q(aux_out_q), .aux_oe_q(aux_oe_q),
    .frac_dynamic_q(frac_dynamic_q), .effective_ratio_q(effective_ratio_q),
    .locked_q(locked_q)
  );

  mpr_pin_ctl i_ctl (
    .clock(clock), .rstn(rstn), .mode_select_low_pin(mode_lo),
    .mode_select_high_pin(mode_hi), .function_pin(fn_pin)
  );

  // ==========================================================================
  // Monitor: oldest note against each read completion or pin probe
  always @(posedge clock) begin
    logic [63:0] e;
    logic [31:0] pv;
    pv = {27'h0, synth_out_q, locked_q, synth_oe_q, aux_oe_q, aux_out_q};
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      `CHK(avs_readdata & e[63:32], e[31:0], "read data")
    end
    if (probe) begin
      e = exp_q.pop_front();
      `CHK(pv & e[63:32], e[31:0], "pins")
    end
  end

  // ==========================================================================
  // Tasks
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int n;
    n = 0;
    if (!wr)
      exp_q.push_back({m, d & m});
    @(posedge clock);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= wr ? d : 32'h0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, e, m);
  endtask

  // Bits: synth level, locked, synth enable, aux enable, aux level
  task automatic look(input logic [4:0] v, input logic [4:0] m);
    exp_q.push_back({27'h0, m, 27'h0, v & m});
    @(posedge clock);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask

  task automatic wait_lock();
    int n;
    n = 0;
    while (locked_q !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (locked_q !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(10305));
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    i_ctl.init_toggle();
    rd(OFS_CTRL, 32'h0, 32'hffff_ffff);
    rd(OFS_RATIO0, RATIO_RST, 32'hffff_ffff);
    rd(OFS_MODAL0, 32'h0, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    rd(8'h22, 32'h0, 32'hffff_ffff);
    // Each set routes its own source; forcing overrides with pin high
    wr(OFS_CTRL, 32'h7);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MODAL0 + 8'(4 * m), 32'(m) << 2);
      for (int f = 0; f < 2; f++) begin
        i_ctl.set_pins(2'(m), 1'(f));
        repeat (8) @(posedge clock);
        rd(OFS_STATUS, 32'({(f ? 2'b10 : 2'(m)), 4'h0, 1'(f), 2'(m)}), 32'h187);
      end
    end
    // Set 1 is automatic at reset, set 0 is manual
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL, 32'h4);
      i_ctl.set_pins(2'd1, 1'(f));
      repeat (8) @(posedge clock);
      rd(OFS_STATUS, 32'(f == 0) << 5, 32'h20);
      wr(OFS_CTRL, 32'h6);
      i_ctl.set_pins(2'd0, 1'(f));
      repeat (8) @(posedge clock);
      rd(OFS_STATUS, 32'(f) << 4, 32'h10);
    end
    r = $urandom();
    wr(OFS_RATIO0, r);
    wr(OFS_CTRL, 32'h3);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MODAL0, 32'(s));
      i_ctl.set_pins(2'd0, 1'b1);
      repeat (8) @(posedge clock);
      rd(OFS_EFF, r >> (s + 1), 32'hffff_ffff);
    end
    i_ctl.set_pins(2'd0, 1'b0);
    repeat (8) @(posedge clock);
    rd(OFS_EFF, r, 32'hffff_ffff);
    wr(OFS_CTRL, 32'h0);
    i_ctl.set_pins(2'd0, 1'b1);
    repeat (8) @(posedge clock);
    rd(OFS_EFF, r, 32'hffff_ffff);
    // Disable targets per function code, auxiliary source is the reference
    for (int t = 0; t < 4; t++) begin
      wr(OFS_CTRL, 32'(t));
      for (int f = 0; f < 2; f++) begin
        i_ctl.set_pins(2'd0, 1'(f));
        repeat (10) @(posedge clock);
        look({1'b0, !(f && t != 1 && t != 3), !(f && t != 0 && t != 3), 1'b0}, 4'h6);
      end
    end
    // Lock indicator styles, unlocked by a stalled reference
    wr(OFS_MODAL0, 32'hc);
    for (int y = 0; y < 2; y++) begin
      wr(OFS_CTRL, (32'(y) << 3) | 32'h1);
      i_ctl.set_pins(2'd0, 1'b0);
      wait_lock();
      look({1'b1, 1'b0, (y == 0), 1'b0}, (y != 0) ? 4'ha : 4'hb);
      ref_valid <= 1'b0;
      repeat (8) @(posedge clock);
      look({1'b0, 1'b0, 1'b1, (y == 0)}, 4'hb);
      ref_valid <= 1'b1;
      // Function pin floats the lock indicator too
      i_ctl.set_pins(2'd0, 1'b1);
      repeat (8) @(posedge clock);
      look(5'h00, 5'h02);
    end
    // Mode change unlocks, holds, then relocks
    wait_lock();
    i_ctl.set_pins(2'd2, 1'b0);
    repeat (6) @(posedge clock);
    look(4'h0, 4'h8);
    repeat (25) @(posedge clock);
    look(5'h00, 5'h18);
    wait_lock();
    look(4'h8, 4'h8);
    // Sync clock: automatic set turns dynamic, a period step unlocks, loss times out
    wr(OFS_CTRL, 32'h0);
    i_ctl.set_pins(2'd1, 1'b0);
    sync_half <= 10;
    repeat (120) @(posedge clock);
    rd(OFS_STATUS, 32'h230, 32'h230);
    wait_lock();
    sync_half <= 3;
    repeat (16) @(posedge clock);
    look(5'h00, 5'h08);
    sync_half <= 0;
    repeat (250) @(posedge clock);
    rd(OFS_STATUS, 32'h020, 32'h230);
    repeat (4) @(posedge clock);
    tally_and_finish();
  end

endmodule
